// [rtl/ebs_pkg.sv]
// package: constants, register map and carrier types of the brake sequencer
package ebs_pkg;

   // ==========================================================
   // timebase
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
   localparam int DLY_W = 16;
   localparam logic [DLY_W-1:0] DEBOUNCE_MS = 16'h0064;
   localparam logic [DLY_W-1:0] MAGNETIZE_MS = 16'h0064;
   localparam logic [DLY_W-1:0] DEMAG_MS = 16'h00c8;

   // ==========================================================
   // register map, byte addresses
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] REG_REL_DLY = 5'h04;
   localparam logic [ADDR_W-1:0] REG_APP_DLY = 5'h08;
   localparam logic [ADDR_W-1:0] REG_LOAD_TIME = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;

   // control fields
   localparam int CTRL_W = 3;
   localparam int CTRL_DIG_MAG_BIT = 0;
   localparam int CTRL_RELAY_BRAKE_BIT = 1;
   localparam int CTRL_CONT_DEV_BIT = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;
   localparam logic [DLY_W-1:0] REL_DLY_RST = 16'h0064;
   localparam logic [DLY_W-1:0] APP_DLY_RST = 16'h0064;
   localparam logic [DLY_W-1:0] LOAD_TIME_RST = 16'h0000;

   // status fields
   localparam int STS_STATE_LSB = 0;
   localparam int STS_BRAKE_BIT = 4;
   localparam int STS_MAG_BIT = 5;
   localparam int STS_OUTEN_BIT = 6;
   localparam int STS_CONT_BIT = 7;
   localparam int STS_PROFILE_BIT = 8;
   localparam int STS_EXT_BIT = 9;
   localparam int STS_TRIP_BIT = 10;

   // ==========================================================
   // sequence states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_DEBOUNCE = 4'h1,
      ST_MAGNETIZE = 4'h2,
      ST_RELEASE = 4'h3,
      ST_TRAVEL = 4'h4,
      ST_APPLY = 4'h5,
      ST_STANDSTILL = 4'h6,
      ST_EXT_RUN = 4'h7,
      ST_DEMAG = 4'h8,
      ST_TRIPPED = 4'h9
   } ebs_state_t;

   // ==========================================================
   // carriers
   localparam int PIN_W = 5;
   typedef struct packed {
      logic enable;
      logic speed_req;
      logic direction;
      logic at_floor;
      logic trip;
   } ebs_pins_t;

   typedef struct packed {
      logic brake;
      logic magnetized;
      logic output_en;
      logic contactor;
      logic profile_run;
   } ebs_drive_t;

endpackage

// [rtl/ebs_delay_timer.sv]
// millisecond delay counter driven from an internal cycle prescaler
module ebs_delay_timer
   import ebs_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // control
   input wire logic restart,
   input wire logic [DLY_W-1:0] target_ms,
   // status
   output logic done
);

   localparam int PRE_W = $clog2(MS_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

   logic [PRE_W-1:0] pre_q;
   logic [DLY_W-1:0] ms_q;
   logic tick;

   // ==========================================================
   // prescaler, restarted so every delay is whole milliseconds
   assign tick = (pre_q == PRE_LAST);

   always_ff @(posedge CLK) begin
      if (SYS_RST || restart || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // whole ms count
   // saturates at target so a long wait never wraps
   always_ff @(posedge CLK) begin
      if (SYS_RST || restart) begin
         ms_q <= '0;
      end else if (tick && ms_q < target_ms) begin
         ms_q <= ms_q + 1'b1;
      end
   end

   assign done = (ms_q >= target_ms);

endmodule

// [rtl/ebs_brake_sequencer.sv]
// brake, magnetizing and contactor sequencer with its Avalon-MM register slave
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module ebs_brake_sequencer
   import ebs_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // controller pins, asynchronous
   input wire logic ENABLE,
   input wire logic SPEED_REQ,
   input wire logic DIRECTION,
   input wire logic AT_FLOOR,
   input wire logic TRIP,
   // drive outputs
   output logic DIGITAL_OUT_T25,
   output logic RELAY_OUT_T41,
   output logic CONTACTOR_OUT_T22,
   output logic OUTPUT_ENABLE,
   output logic HOLD_ZERO_SPEED,
   output logic PROFILE_RUN,
   output logic PROFILE_DIR
);

   // ==========================================================
   // declarations
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] sync1_q;
   logic [PIN_W-1:0] sync2_q;
   ebs_pins_t pin_s;
   logic [CTRL_W-1:0] ctrl_q;
   logic [DLY_W-1:0] rel_dly_q;
   logic [DLY_W-1:0] app_dly_q;
   logic [DLY_W-1:0] load_time_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wr_take;
   ebs_state_t state_q;
   ebs_state_t state_d;
   logic ext_q;
   logic dly_done;
   logic [DLY_W-1:0] dly_target;
   logic [DLY_W-1:0] start_wait;
   ebs_drive_t drv_d;
   ebs_drive_t drv_q;
   logic t25_q;
   logic relay_q;
   logic t22_q;
   logic dir_q;

   // merge a 16-bit field with the two low byte lanes
   function automatic logic [DLY_W-1:0] be_merge16(input logic [DLY_W-1:0] old,
                                                   input logic [31:0] wdata,
                                                   input logic [3:0] be);
      logic [DLY_W-1:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // ==========================================================
   // pin synchronisers
   assign pins_raw = {ENABLE, SPEED_REQ, DIRECTION, AT_FLOOR, TRIP};

   // two stages per pin; only the second stage feeds logic
   generate
      for (genvar i = 0; i < PIN_W; i++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               sync1_q[i] <= 1'b0;
               sync2_q[i] <= 1'b0;
            end else begin
               sync1_q[i] <= pins_raw[i];
               sync2_q[i] <= sync1_q[i];
            end
         end
      end
   endgenerate

   assign pin_s = ebs_pins_t'(sync2_q);

   // ==========================================================
   // avalon slave handshake: one wait cycle per access
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
   assign wr_take = AVS_WRITE && ack_q;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
      end
   end

   // separate delays
   // writes land only at the edge after waitrequest drops
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_q <= CTRL_RST;
         rel_dly_q <= REL_DLY_RST;
         app_dly_q <= APP_DLY_RST;
         load_time_q <= LOAD_TIME_RST;
      end else if (wr_take) begin
         unique case (AVS_ADDRESS[ADDR_W-1:2])
            REG_CTRL[ADDR_W-1:2]: begin
               if (AVS_BYTEENABLE[0]) begin
                  ctrl_q <= AVS_WRITEDATA[CTRL_W-1:0];
               end
            end
            REG_REL_DLY[ADDR_W-1:2]: begin
               rel_dly_q <= be_merge16(rel_dly_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            REG_APP_DLY[ADDR_W-1:2]: begin
               app_dly_q <= be_merge16(app_dly_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            REG_LOAD_TIME[ADDR_W-1:2]: begin
               load_time_q <= be_merge16(load_time_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            default: begin
               // status and unmapped words ignore writes
            end
         endcase
      end
   end

   // read mux; unmapped words read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (AVS_ADDRESS[ADDR_W-1:2])
         REG_CTRL[ADDR_W-1:2]: rdata_d[CTRL_W-1:0] = ctrl_q;
         REG_REL_DLY[ADDR_W-1:2]: rdata_d[DLY_W-1:0] = rel_dly_q;
         REG_APP_DLY[ADDR_W-1:2]: rdata_d[DLY_W-1:0] = app_dly_q;
         REG_LOAD_TIME[ADDR_W-1:2]: rdata_d[DLY_W-1:0] = load_time_q;
         REG_STATUS[ADDR_W-1:2]: begin
            rdata_d[STS_STATE_LSB+3:STS_STATE_LSB] = state_q;
            rdata_d[STS_BRAKE_BIT] = drv_q.brake;
            rdata_d[STS_MAG_BIT] = drv_q.magnetized;
            rdata_d[STS_OUTEN_BIT] = drv_q.output_en;
            rdata_d[STS_CONT_BIT] = drv_q.contactor;
            rdata_d[STS_PROFILE_BIT] = drv_q.profile_run;
            rdata_d[STS_EXT_BIT] = ext_q;
            rdata_d[STS_TRIP_BIT] = pin_s.trip;
         end
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // captured on the waiting edge so it stands when waitrequest drops
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rdata_q <= 32'h0000_0000;
      end else if (AVS_READ && !ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   assign AVS_READDATA = rdata_q;

   // ==========================================================
   // step delays
   // longer of release delay and load time
   assign start_wait = (rel_dly_q > load_time_q) ? rel_dly_q : load_time_q;

   always_comb begin
      unique case (state_q)
         ST_DEBOUNCE: dly_target = DEBOUNCE_MS;
         ST_MAGNETIZE: dly_target = MAGNETIZE_MS;
         ST_RELEASE: dly_target = start_wait;
         ST_APPLY: dly_target = app_dly_q;
         ST_DEMAG: dly_target = DEMAG_MS;
         default: dly_target = '0;
      endcase
   end

   ebs_delay_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .restart(state_d != state_q),
      .target_ms(dly_target),
      .done(dly_done)
   );

   // ==========================================================
   // sequence state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (pin_s.enable) begin
               state_d = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (!pin_s.enable) begin
               state_d = ST_IDLE;
            end else if (dly_done) begin
               state_d = ST_MAGNETIZE;
            end
         end
         ST_MAGNETIZE: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end else if (dly_done) begin
               state_d = ext_q ? ST_EXT_RUN : ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end else if (dly_done) begin
               state_d = ST_TRAVEL;
            end
         end
         ST_TRAVEL: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end else if (!pin_s.speed_req && pin_s.at_floor) begin
               state_d = ST_APPLY;
            end
         end
         ST_APPLY: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end else if (dly_done) begin
               state_d = ST_STANDSTILL;
            end
         end
         ST_STANDSTILL: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end
         end
         ST_EXT_RUN: begin
            if (!pin_s.enable) begin
               state_d = ST_DEMAG;
            end
         end
         ST_DEMAG: begin
            if (dly_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_TRIPPED: begin
            // stays down until trip clears and enable is withdrawn
            if (!pin_s.trip && !pin_s.enable) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (pin_s.trip) begin
         state_d = ST_TRIPPED;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // mode latched per travel; a mid-run change would confuse the brake owner
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ext_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         ext_q <= ctrl_q[CTRL_DIG_MAG_BIT];
      end
   end

   // ==========================================================
   // drive outputs decoded from the next state
   always_comb begin
      drv_d = '0;
      // brake released only in drive mode
      drv_d.brake = !ext_q && (state_d == ST_RELEASE || state_d == ST_TRAVEL);
      // magnetized once the 100 ms step is over
      drv_d.magnetized = (state_d == ST_RELEASE) || (state_d == ST_TRAVEL) ||
                         (state_d == ST_APPLY) || (state_d == ST_STANDSTILL) ||
                         (state_d == ST_EXT_RUN);
      drv_d.output_en = drv_d.magnetized || (state_d == ST_MAGNETIZE) ||
                        (state_d == ST_DEMAG);
      drv_d.contactor = drv_d.output_en || (state_d == ST_DEBOUNCE);
      // profile only after start wait or in external run; speed applied by controller
      drv_d.profile_run = pin_s.speed_req &&
                          (state_d == ST_TRAVEL || state_d == ST_EXT_RUN);
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         t25_q <= 1'b0;
         relay_q <= 1'b0;
         t22_q <= 1'b0;
      end else begin
         t25_q <= ctrl_q[CTRL_DIG_MAG_BIT] ? drv_d.magnetized : drv_d.brake;
         relay_q <= ctrl_q[CTRL_RELAY_BRAKE_BIT] && drv_d.brake;
         t22_q <= ctrl_q[CTRL_CONT_DEV_BIT] && drv_d.contactor;
      end
   end

   // direction frozen at profile start
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dir_q <= 1'b0;
      end else if (drv_d.profile_run && !drv_q.profile_run) begin
         dir_q <= pin_s.direction;
      end
   end

   assign DIGITAL_OUT_T25 = t25_q;
   assign RELAY_OUT_T41 = relay_q;
   assign CONTACTOR_OUT_T22 = t22_q;
   assign OUTPUT_ENABLE = drv_q.output_en;
   assign HOLD_ZERO_SPEED = !drv_q.profile_run;
   assign PROFILE_RUN = drv_q.profile_run;
   assign PROFILE_DIR = dir_q;

   // ==========================================================
   // assertions
   AST_TRIP_BRAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
      pin_s.trip |=> !drv_q.brake && !relay_q ##1 !t25_q || ctrl_q[CTRL_DIG_MAG_BIT])
      else $error("brake still released after trip");

   AST_T25_ROUTE: assert property (@(posedge CLK) disable iff (SYS_RST)
      !ctrl_q[CTRL_DIG_MAG_BIT] && $stable(ctrl_q) |=> t25_q == drv_q.brake)
      else $error("terminal 25 does not follow brake signal");

   AST_RELAY_ROUTE: assert property (@(posedge CLK) disable iff (SYS_RST)
      $stable(ctrl_q) |=> relay_q == ($past(ctrl_q[CTRL_RELAY_BRAKE_BIT]) && drv_q.brake))
      else $error("relay output routing wrong");

   AST_DEBOUNCE_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
      state_q == ST_DEBOUNCE |-> !drv_q.output_en)
      else $error("power output enabled during debounce");

   AST_MAG_FIRST: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(drv_q.brake) |-> $past(state_q, 2) == ST_MAGNETIZE && $past(drv_q.output_en))
      else $error("brake released without magnetizing");

   AST_ZERO_SPEED: assert property (@(posedge CLK) disable iff (SYS_RST)
      state_q == ST_RELEASE |-> HOLD_ZERO_SPEED && !PROFILE_RUN)
      else $error("speed profile during release wait");

   AST_APPLY_BRAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
      state_q == ST_APPLY || state_q == ST_STANDSTILL |-> !drv_q.brake)
      else $error("brake still released at floor");

   AST_DEMAG_CONT: assert property (@(posedge CLK) disable iff (SYS_RST)
      $fell(drv_q.contactor) && !$past(pin_s.trip) |-> $past(state_q) == ST_DEMAG ||
      $past(state_q) == ST_DEBOUNCE)
      else $error("contactor opened before demagnetizing");

   AST_EXT_NO_BRAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
      state_q == ST_EXT_RUN |-> drv_q.magnetized && !drv_q.brake)
      else $error("external mode magnetized flag wrong");

   AST_ABORT_BRAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
      state_q == ST_TRAVEL && !pin_s.enable && !pin_s.trip |=>
      !drv_q.brake && state_q == ST_DEMAG)
      else $error("enable loss in travel did not apply brake");

endmodule

// [tb/ebs_ctrl_model.sv]
// elevator controller model driving the enable, direction and speed pins
module ebs_ctrl_model
   import ebs_pkg::*;
#(
   parameter int MS_CYCLES = 10
) (
   // clock and drive feedback
   input wire logic CLK,
   input wire logic magnetized,
   // controller pins
   output logic enable,
   output logic speed_req,
   output logic direction,
   output logic at_floor
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // pins idle at time zero
   initial begin
      enable = 1'b0;
      speed_req = 1'b0;
      direction = 1'b0;
      at_floor = 1'b0;
   end

   task automatic start_drive(input logic dir);
      @(posedge CLK);
      direction <= dir;
      speed_req <= 1'b1;
      repeat (5) @(posedge CLK);
      enable <= 1'b1;
   endtask

   task automatic raise_enable();
      @(posedge CLK);
      enable <= 1'b1;
   endtask

   // magnetized seen, own release delay, then speed
   // no local limit; a flag that never comes is caught by the bench watchdog
   task automatic apply_speed(input logic dir, input int rel_ms);
      while (magnetized !== 1'b1) begin
         @(posedge CLK);
      end
      repeat (rel_ms * MS_CYCLES) @(posedge CLK);
      direction <= dir;
      speed_req <= 1'b1;
   endtask

   // withdraw speed, car reaches the floor later
   task automatic stop_travel();
      @(posedge CLK);
      speed_req <= 1'b0;
      repeat (20) @(posedge CLK);
      at_floor <= 1'b1;
   endtask

   // enable drops only after the apply delay
   task automatic finish(input int app_ms);
      repeat (app_ms * MS_CYCLES + 5) @(posedge CLK);
      enable <= 1'b0;
      at_floor <= 1'b0;
   endtask

   // abort in mid-travel, enable and speed withdrawn at once
   task automatic abort();
      @(posedge CLK);
      enable <= 1'b0;
      speed_req <= 1'b0;
   endtask
endmodule

// [tb/ebs_brake_sequencer_bench.sv]
// self-checking bench for the brake sequencer and its controller model
module ebs_brake_sequencer_bench
   import ebs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // short millisecond so long delays stay cheap
   localparam int MSC = 10;
   localparam int DEB = int'(DEBOUNCE_MS) * MSC;
   localparam int MAG = int'(MAGNETIZE_MS) * MSC;
   localparam int DMG = int'(DEMAG_MS) * MSC;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [ADDR_W-1:0] AVS_ADDRESS = '0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = '0;
   logic [3:0] AVS_BYTEENABLE = 4'hf;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic ENABLE, SPEED_REQ, DIRECTION, AT_FLOOR;
   logic TRIP = 1'b0;
   logic DIGITAL_OUT_T25, RELAY_OUT_T41, CONTACTOR_OUT_T22, OUTPUT_ENABLE;
   logic HOLD_ZERO_SPEED, PROFILE_RUN, PROFILE_DIR;
   logic [31:0] d;
   int err_count = 0;
   int num_checks = 0;

   always #50 CLK = ~CLK;

   ebs_brake_sequencer #(.MS_CYCLES(MSC)) DUT (.CLK(CLK), .SYS_RST(SYS_RST),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .ENABLE(ENABLE), .SPEED_REQ(SPEED_REQ), .DIRECTION(DIRECTION),
      .AT_FLOOR(AT_FLOOR), .TRIP(TRIP), .DIGITAL_OUT_T25(DIGITAL_OUT_T25),
      .RELAY_OUT_T41(RELAY_OUT_T41), .CONTACTOR_OUT_T22(CONTACTOR_OUT_T22),
      .OUTPUT_ENABLE(OUTPUT_ENABLE), .HOLD_ZERO_SPEED(HOLD_ZERO_SPEED),
      .PROFILE_RUN(PROFILE_RUN), .PROFILE_DIR(PROFILE_DIR));

   ebs_ctrl_model #(.MS_CYCLES(MSC)) u_ctrl (.CLK(CLK), .magnetized(DIGITAL_OUT_T25),
      .enable(ENABLE), .speed_req(SPEED_REQ), .direction(DIRECTION),
      .at_floor(AT_FLOOR));

   // ==========================================
   // verdict, the single exit of the run
   task automatic complete_run();
      if (err_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h", $time, msg, got);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return DIGITAL_OUT_T25;
         1: return CONTACTOR_OUT_T22;
         2: return OUTPUT_ENABLE;
         default: return PROFILE_RUN;
      endcase
   endfunction

   // cycles until an output takes a level, judged against a window
   task automatic wait_bit(input int s, input logic v, input int lo, input int hi,
                           input string msg);
      int n;
      n = 0;
      while (pick(s) !== v && n <= hi) begin
         @(posedge CLK);
         #1;
         n++;
      end
      chk_bit(n >= lo && n <= hi, 1'b1, msg);
   endtask

   // ==========================================
   // avalon master: hold until waitrequest is seen low
   // no local limit; a stuck slave is caught by the watchdog
   task automatic av_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= wd;
      AVS_WRITE <= wr;
      AVS_READ <= ~wr;
      do begin
         @(posedge CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      d = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask

   // ==========================================
   // reset values, unmapped and read-only places, delay settings
   task automatic t_regs();
      av_xfer(1'b0, REG_CTRL, '0);
      chk_word(d, {29'h0, CTRL_RST}, "ctrl reset");
      av_xfer(1'b0, REG_REL_DLY, '0);
      chk_word(d, {16'h0, REL_DLY_RST}, "release reset");
      av_xfer(1'b0, REG_APP_DLY, '0);
      chk_word(d, {16'h0, APP_DLY_RST}, "apply reset");
      av_xfer(1'b0, 5'h14, '0);
      chk_word(d, 32'h0, "unmapped read");
      av_xfer(1'b1, REG_STATUS, 32'hffff_ffff);
      av_xfer(1'b0, REG_STATUS, '0);
      chk_word(d, 32'h0, "status idle");
      // small non-zero release delay, load time longer
      av_xfer(1'b1, REG_REL_DLY, 32'h3);
      av_xfer(1'b1, REG_APP_DLY, 32'h4);
      av_xfer(1'b1, REG_LOAD_TIME, 32'h5);
      av_xfer(1'b0, REG_REL_DLY, '0);
      chk_word(d, 32'h3, "release readback");
      av_xfer(1'b0, REG_LOAD_TIME, '0);
      chk_word(d, 32'h5, "load readback");
   endtask

   // drive-controlled travel: normal stop, or abort with relay routing
   task automatic t_drive(input logic relay);
      av_xfer(1'b1, REG_CTRL, relay ? 32'h2 : 32'h4);
      u_ctrl.start_drive(1'b1);
      if (!relay) wait_bit(1, 1'b1, 0, 8, "contactor close");
      wait_bit(2, 1'b1, DEB - 10, DEB + 20, "debounce");
      wait_bit(0, 1'b1, MAG - 5, MAG + 10, "magnetize");
      chk_bit(RELAY_OUT_T41, relay, "relay route");
      chk_bit(CONTACTOR_OUT_T22, ~relay, "contactor owner");
      wait_bit(3, 1'b1, 5 * MSC - 5, 5 * MSC + 10, "zero speed hold");
      chk_bit(HOLD_ZERO_SPEED, 1'b0, "hold off");
      chk_bit(PROFILE_DIR, 1'b1, "direction");
      if (relay) begin
         u_ctrl.abort();
         wait_bit(0, 1'b0, 0, 6, "abort brake");
         chk_bit(RELAY_OUT_T41, 1'b0, "relay abort");
         wait_bit(2, 1'b0, DMG - 10, DMG + 20, "abort demag");
      end else begin
         u_ctrl.stop_travel();
         wait_bit(0, 1'b0, 0, 8, "brake apply");
         chk_bit(OUTPUT_ENABLE, 1'b1, "still powered");
         u_ctrl.finish(4);
         wait_bit(2, 1'b0, DMG - 10, DMG + 20, "demag");
         wait_bit(1, 1'b0, 0, 3, "contactor open");
      end
   endtask

   // trip once the brake is lifted
   task automatic t_trip();
      av_xfer(1'b1, REG_CTRL, 32'h4);
      u_ctrl.start_drive(1'b0);
      wait_bit(0, 1'b1, DEB + MAG - 10, DEB + MAG + 40, "lift before trip");
      @(posedge CLK);
      TRIP <= 1'b1;
      wait_bit(0, 1'b0, 0, 6, "trip brake");
      chk_bit(OUTPUT_ENABLE, 1'b0, "trip power");
      u_ctrl.abort();
      repeat (5) @(posedge CLK);
      TRIP <= 1'b0;
      repeat (10) @(posedge CLK);
      av_xfer(1'b0, REG_STATUS, '0);
      chk_word(d & 32'hf, 32'h0, "idle after trip");
   endtask

   // controller owns the brake, T25 shows magnetized, device owns the contactor
   task automatic t_ext();
      av_xfer(1'b1, REG_CTRL, 32'h5);
      u_ctrl.raise_enable();
      wait_bit(2, 1'b1, DEB - 10, DEB + 20, "ext debounce");
      wait_bit(0, 1'b1, MAG - 5, MAG + 10, "magnetized flag");
      chk_bit(CONTACTOR_OUT_T22, 1'b1, "ext contactor closed");
      chk_bit(PROFILE_RUN, 1'b0, "no speed yet");
      u_ctrl.apply_speed(1'b0, 3);
      wait_bit(3, 1'b1, 0, 8, "ext profile");
      u_ctrl.stop_travel();
      u_ctrl.finish(4);
      wait_bit(2, 1'b0, DMG - 10, DMG + 20, "ext demag");
      chk_bit(CONTACTOR_OUT_T22, 1'b0, "ext contactor");
   endtask

   // watchdog well beyond the expected run
   initial begin
      repeat (40000) @(posedge CLK);
      err_count++;
      complete_run();
   end

   initial begin
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_regs();
      t_drive(1'b0);
      t_drive(1'b1);
      t_trip();
      t_ext();
      complete_run();
   end
endmodule
